// ### mdiu_pkg.sv
// Constants and carrier types shared by the MAC DMA interrupt unit.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package mdiu_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Bus geometry.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int BE_W   = 4;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets.
   localparam logic [ADDR_W-1:0] OFS_TX_START = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_RX_START = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 8'h28;
   localparam logic [ADDR_W-1:0] OFS_IRQ_ST   = 8'h2C;
   localparam logic [ADDR_W-1:0] OFS_DMA_ST   = 8'h30;

   ////////////////////////////////////////////////////////////////////////
   // Source field layout, shared by the enable and status registers.
   localparam int NUM_SRC          = 7;
   localparam int SRC_LSB          = 25;
   localparam int SRC_MSB          = 31;
   localparam int BIT_LINK_CHANGE  = 31;
   localparam int BIT_TX_DONE      = 30;
   localparam int BIT_RX_DONE      = 29;
   localparam int BIT_TX_UNAVAIL   = 28;
   localparam int BIT_RX_UNAVAIL   = 27;
   localparam int BIT_TX_STOPPED   = 26;
   localparam int BIT_RX_STOPPED   = 25;
   localparam int SRC_LANE         = 3;

   // State readback layout.
   localparam int BIT_TX_SUSP      = 0;
   localparam int BIT_RX_SUSP      = 1;

   ////////////////////////////////////////////////////////////////////////
   // Reset values.
   localparam logic [NUM_SRC-1:0] IRQ_EN_RST = 7'h00;
   localparam logic [NUM_SRC-1:0] IRQ_ST_RST = 7'h00;
   localparam logic [DATA_W-1:0]  RDATA_RST  = 32'h00000000;
   localparam logic [DATA_W-1:0]  RDATA_NONE = 32'h00000000;

   ////////////////////////////////////////////////////////////////////////
   // Events from the DMA engines and the MAC.
   typedef struct packed {
      logic link_up;
      logic tx_frame_done;
      logic rx_frame_ready;
      logic tx_desc_host_owned;
      logic rx_desc_fetch;
      logic rx_desc_host_owned;
      logic rx_frame_arrival;
      logic tx_stopped;
      logic rx_stopped;
   } mdiu_evt_t;

   // Controls back to the DMA engines.
   typedef struct packed {
      logic tx_start_command;
      logic rx_start_command;
      logic rx_resume;
      logic tx_suspended;
      logic rx_suspended;
   } mdiu_ctl_t;

   typedef enum logic [0:0] {
      MDIU_BUS_IDLE = 1'b0,
      MDIU_BUS_ACK  = 1'b1
   } mdiu_bus_t;

endpackage

// ### mdiu_sticky.sv
// One sticky status flag with write-one-to-clear and its enable bit.
// Assumes set and clear are single-cycle, synchronous to clk.
`timescale 1ns/1ps
module mdiu_sticky (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst_n,
   // Controls.
   input  wire logic set_evt,
   input  wire logic clr_wr,
   input  wire logic en_wr,
   input  wire logic en_val,
   // State.
   output logic      flag,
   output logic      en
);

   ////////////////////////////////////////////////////////////////////////
   logic flag_nxt;
   logic en_nxt;

   // The set term wins so that an event in the clearing cycle survives.
   assign flag_nxt = set_evt | (flag & ~clr_wr);   // [R11] [R15]
   assign en_nxt   = en_wr ? en_val : en;          // [R14]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flag <= 1'b0;
         en   <= 1'b0;
      end else begin
         flag <= flag_nxt;
         en   <= en_nxt;
      end
   end

endmodule

// ### mdiu_top.sv
// MAC DMA interrupt unit: sticky event status, enables, start commands.
// Assumes an Avalon-MM master on the same clock and DMA event strobes.
//
// What this block does
// [R01] Set link-change flag, bit 31, when link goes up or down.
// [R02] Set transmit-done flag, bit 30, after a frame is sent.
// [R03] Set receive-done flag, bit 29, when a received frame awaits host.
// [R04] Host-owned next transmit descriptor sets bit 28 and suspends transmit.
// [R05] Host restarts transmit by returning descriptor then issuing start command.
// [R06] Host-owned fetched receive descriptor sets bit 27 and suspends receive.
// [R07] Without a start command, receive resumes on next recognised frame.
// [R08] Receive-unavailable raised only when previous descriptor was device-owned.
// [R09] Set bit 26 when transmit DMA enters stopped state.
// [R10] Set bit 25 when receive DMA enters stopped state.
// [R11] Status bits are edge-triggered, sticky, cleared only by writing one.
// [R12] Reading status returns bits without clearing them.
// [R13] Interrupt raised while any status bit and its enable are set.
// [R14] Enable bits 31..25 read-write, reset zero; bits 24..0 read zero.
// [R15] Writing zero leaves a bit; a same-cycle event beats the clear.
// [R16] Any write to transmit start register restarts transmit descriptor check.
`timescale 1ns/1ps
module mdiu_top
   import mdiu_pkg::*;
(
   // Clock and reset.
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   // Avalon-MM slave.
   input  wire logic [mdiu_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                      avs_read,
   input  wire logic                      avs_write,
   input  wire logic [mdiu_pkg::DATA_W-1:0] avs_writedata,
   input  wire logic [mdiu_pkg::BE_W-1:0] avs_byteenable,
   output logic      [mdiu_pkg::DATA_W-1:0] avs_readdata,
   output logic                           avs_waitrequest,
   // DMA and MAC events.
   input  wire mdiu_pkg::mdiu_evt_t       evt,
   // DMA controls.
   output mdiu_pkg::mdiu_ctl_t            ctl,
   // Host interrupt.
   output logic                           irq
);

   import mdiu_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake state.
   mdiu_bus_t                 bus_state_r;
   mdiu_bus_t                 bus_state_nxt;
   logic                      waitreq_r;
   logic                      waitreq_nxt;
   logic [DATA_W-1:0]         readdata_r;
   logic [DATA_W-1:0]         readdata_nxt;

   // Decode.
   logic                      req;
   logic                      acc;
   logic                      wr_acc;
   logic                      rd_start;
   logic                      hit_tx_start;
   logic                      hit_rx_start;
   logic                      hit_irq_en;
   logic                      hit_irq_st;
   logic                      hit_dma_st;
   logic                      lane_ok;
   logic                      wr_tx_start;
   logic                      wr_rx_start;
   logic                      wr_irq_en;
   logic                      wr_irq_st;
   logic [NUM_SRC-1:0]        wdata_src;

   // Event detection.
   logic                      link_prev_r;
   logic                      link_seen_r;
   logic                      tx_stop_prev_r;
   logic                      rx_stop_prev_r;
   logic                      rx_prev_dev_r;
   logic                      rx_prev_dev_nxt;
   logic                      link_chg;
   logic                      tx_stop_rise;
   logic                      rx_stop_rise;
   logic                      rx_unavail;
   logic [NUM_SRC-1:0]        set_vec;

   // Suspension and commands.
   logic                      tx_susp_r;
   logic                      tx_susp_nxt;
   logic                      rx_susp_r;
   logic                      rx_susp_nxt;
   logic                      tx_cmd_r;
   logic                      rx_cmd_r;
   logic                      rx_resume_r;
   logic                      rx_resume_nxt;

   // Status and enable.
   logic [NUM_SRC-1:0]        status;
   logic [NUM_SRC-1:0]        enable;
   logic [NUM_SRC-1:0]        pending;
   logic                      irq_r;
   logic [DATA_W-1:0]         st_word;
   logic [DATA_W-1:0]         en_word;
   logic [DATA_W-1:0]         dma_word;

   ////////////////////////////////////////////////////////////////////////
   // Address decode and access qualification.
   // The access completes on the edge where waitrequest is seen low.
   assign req          = avs_read | avs_write;
   assign acc          = req & (bus_state_r == MDIU_BUS_ACK);
   assign wr_acc       = acc & avs_write;
   assign rd_start     = avs_read & (bus_state_r == MDIU_BUS_IDLE);
   assign hit_tx_start = (avs_address == OFS_TX_START);
   assign hit_rx_start = (avs_address == OFS_RX_START);
   assign hit_irq_en   = (avs_address == OFS_IRQ_EN);
   assign hit_irq_st   = (avs_address == OFS_IRQ_ST);
   assign hit_dma_st   = (avs_address == OFS_DMA_ST);
   assign lane_ok      = avs_byteenable[SRC_LANE];
   assign wdata_src    = avs_writedata[SRC_MSB:SRC_LSB];

   // Start commands take any value, so byte enables do not gate them.
   assign wr_tx_start  = wr_acc & hit_tx_start;          // [R16]
   assign wr_rx_start  = wr_acc & hit_rx_start;
   assign wr_irq_en    = wr_acc & hit_irq_en & lane_ok;  // [R14]
   assign wr_irq_st    = wr_acc & hit_irq_st & lane_ok;  // [R11]

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake: one wait cycle, then a single ready cycle.
   always_comb begin
      bus_state_nxt = bus_state_r;
      waitreq_nxt   = 1'b1;
      case (bus_state_r)
         MDIU_BUS_IDLE: begin
            if (req) begin
               bus_state_nxt = MDIU_BUS_ACK;
               waitreq_nxt   = 1'b0;
            end
         end
         MDIU_BUS_ACK: begin
            bus_state_nxt = MDIU_BUS_IDLE;
            waitreq_nxt   = 1'b1;
         end
         default: begin
            bus_state_nxt = MDIU_BUS_IDLE;
            waitreq_nxt   = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Read words. Reserved bits and unmapped offsets read as zero.
   assign st_word  = {status, {SRC_LSB{1'b0}}};
   assign en_word  = {enable, {SRC_LSB{1'b0}}};                    // [R14]
   assign dma_word = {{(DATA_W-2){1'b0}}, rx_susp_r, tx_susp_r};

   // Reading status has no side effect on the flags.
   assign readdata_nxt = !rd_start   ? readdata_r :
                         hit_irq_st  ? st_word    :                // [R12]
                         hit_irq_en  ? en_word    :
                         hit_dma_st  ? dma_word   :
                         RDATA_NONE;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_state_r <= MDIU_BUS_IDLE;
         waitreq_r   <= 1'b1;
         readdata_r  <= RDATA_RST;
      end else begin
         bus_state_r <= bus_state_nxt;
         waitreq_r   <= waitreq_nxt;
         readdata_r  <= readdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event edge detection.
   // The first sample after reset only primes the history, so a link already
   // up or an engine already stopped when reset lifts reports no change.
   assign link_chg     = link_seen_r & (evt.link_up ^ link_prev_r);   // [R01]
   assign tx_stop_rise = link_seen_r & evt.tx_stopped & ~tx_stop_prev_r; // [R09]
   assign rx_stop_rise = link_seen_r & evt.rx_stopped & ~rx_stop_prev_r; // [R10]

   // Only the first host-owned fetch after reset or after a device-owned one reports.
   assign rx_unavail      = evt.rx_desc_fetch & evt.rx_desc_host_owned
                            & rx_prev_dev_r;                          // [R08]
   assign rx_prev_dev_nxt = evt.rx_desc_fetch ? ~evt.rx_desc_host_owned
                                              : rx_prev_dev_r;        // [R08]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         link_prev_r    <= 1'b0;
         link_seen_r    <= 1'b0;
         tx_stop_prev_r <= 1'b0;
         rx_stop_prev_r <= 1'b0;
         rx_prev_dev_r  <= 1'b1;
      end else begin
         link_prev_r    <= evt.link_up;
         link_seen_r    <= 1'b1;
         tx_stop_prev_r <= evt.tx_stopped;
         rx_stop_prev_r <= evt.rx_stopped;
         rx_prev_dev_r  <= rx_prev_dev_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Set vector in status bit order, bit 0 being bit 25 of the word.
   assign set_vec[BIT_LINK_CHANGE-SRC_LSB] = link_chg;                // [R01]
   assign set_vec[BIT_TX_DONE-SRC_LSB]     = evt.tx_frame_done;       // [R02]
   assign set_vec[BIT_RX_DONE-SRC_LSB]     = evt.rx_frame_ready;      // [R03]
   assign set_vec[BIT_TX_UNAVAIL-SRC_LSB]  = evt.tx_desc_host_owned;  // [R04]
   assign set_vec[BIT_RX_UNAVAIL-SRC_LSB]  = rx_unavail;              // [R06]
   assign set_vec[BIT_TX_STOPPED-SRC_LSB]  = tx_stop_rise;            // [R09]
   assign set_vec[BIT_RX_STOPPED-SRC_LSB]  = rx_stop_rise;            // [R10]

   genvar gi;
   generate
      for (gi = 0; gi < NUM_SRC; gi = gi + 1) begin : g_src
         mdiu_sticky u_flag (
            .clk     (clk),
            .rst_n   (rst_n),
            .set_evt (set_vec[gi]),
            .clr_wr  (wr_irq_st & wdata_src[gi]),                     // [R15]
            .en_wr   (wr_irq_en),
            .en_val  (wdata_src[gi]),
            .flag    (status[gi]),
            .en      (enable[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Interrupt: masked status, one level output.
   assign pending = status & enable;                                  // [R13]

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |pending;                                           // [R13]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit suspension. A start command clears it; the engine rechecks
   // the ring and, if the descriptor is still host-owned, reports again.
   always_comb begin
      tx_susp_nxt = tx_susp_r;
      if (evt.tx_desc_host_owned) begin
         tx_susp_nxt = 1'b1;                                          // [R04]
      end else if (tx_cmd_r) begin
         tx_susp_nxt = 1'b0;                                          // [R05] [R16]
      end
   end

   // Receive suspension ends on a start command or on the next
   // recognised frame, whichever comes first.
   always_comb begin
      rx_susp_nxt   = rx_susp_r;
      rx_resume_nxt = 1'b0;
      if (evt.rx_desc_fetch & evt.rx_desc_host_owned) begin
         rx_susp_nxt = 1'b1;                                          // [R06]
      end else if (rx_susp_r & rx_cmd_r) begin
         rx_susp_nxt = 1'b0;
      end else if (rx_susp_r & evt.rx_frame_arrival) begin
         rx_susp_nxt   = 1'b0;                                        // [R07]
         rx_resume_nxt = 1'b1;                                        // [R07]
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_susp_r   <= 1'b0;
         rx_susp_r   <= 1'b0;
         tx_cmd_r    <= 1'b0;
         rx_cmd_r    <= 1'b0;
         rx_resume_r <= 1'b0;
      end else begin
         tx_susp_r   <= tx_susp_nxt;
         rx_susp_r   <= rx_susp_nxt;
         tx_cmd_r    <= wr_tx_start;                                  // [R16]
         rx_cmd_r    <= wr_rx_start;
         rx_resume_r <= rx_resume_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from flip-flops.
   assign avs_readdata         = readdata_r;
   assign avs_waitrequest      = waitreq_r;
   assign irq                  = irq_r;
   assign ctl.tx_start_command = tx_cmd_r;
   assign ctl.rx_start_command = rx_cmd_r;
   assign ctl.rx_resume        = rx_resume_r;
   assign ctl.tx_suspended     = tx_susp_r;
   assign ctl.rx_suspended     = rx_susp_r;

endmodule

// ### mdiu_top_sva.sv
// Concurrent checks on the ports of the MAC DMA interrupt unit top.
// Assumes binding to mdiu_top; status bits are seen only through reads.
`timescale 1ns/1ps
module mdiu_top_sva
   import mdiu_pkg::*;
(
   // Clock and reset.
   input wire logic                          clk,
   input wire logic                          rst_n,
   // Bus.
   input wire logic [mdiu_pkg::ADDR_W-1:0]   avs_address,
   input wire logic                          avs_read,
   input wire logic                          avs_write,
   input wire logic [mdiu_pkg::DATA_W-1:0]   avs_writedata,
   input wire logic [mdiu_pkg::BE_W-1:0]     avs_byteenable,
   input wire logic [mdiu_pkg::DATA_W-1:0]   avs_readdata,
   input wire logic                          avs_waitrequest,
   // Events, controls, interrupt.
   input wire mdiu_pkg::mdiu_evt_t           evt,
   input wire mdiu_pkg::mdiu_ctl_t           ctl,
   input wire logic                          irq
);
   import mdiu_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////
   sequence s_wr(logic [7:0] a);
      avs_write && !avs_waitrequest && avs_address == a;
   endsequence
   sequence s_rd(logic [7:0] a);
      avs_read && !avs_waitrequest && avs_address == a;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   a_wait_drop: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest stayed high after a request.");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle.");
   a_tx_start: assert property (s_wr(OFS_TX_START) |=> ctl.tx_start_command)
      else $error("no transmit start pulse after write.");
   a_rx_start: assert property (s_wr(OFS_RX_START) |=> ctl.rx_start_command)
      else $error("no receive start pulse after write.");
   a_start_pulse: assert property (ctl.tx_start_command |=> !ctl.tx_start_command)
      else $error("transmit start pulse too long.");
   a_tx_suspend: assert property (evt.tx_desc_host_owned |-> ##[1:2] ctl.tx_suspended)
      else $error("transmit not suspended.");
   a_tx_restart: assert property (ctl.tx_start_command && !evt.tx_desc_host_owned
      |-> ##[1:2] !ctl.tx_suspended)
      else $error("transmit stayed suspended after start.");
   a_resume_cause: assert property (ctl.rx_resume |-> $past(evt.rx_frame_arrival)
      || $past(evt.rx_frame_arrival, 2))
      else $error("receive resume without a frame arrival.");
   a_rd_start: assert property (s_rd(OFS_TX_START) |-> avs_readdata == RDATA_NONE)
      else $error("start register read not zero.");
   a_en_reserved: assert property (s_rd(OFS_IRQ_EN) |-> avs_readdata[24:0] == 25'h0)
      else $error("enable reserved bits not zero.");
   a_st_reserved: assert property (s_rd(OFS_IRQ_ST) |-> avs_readdata[24:0] == 25'h0)
      else $error("status reserved bits not zero.");
   a_irq_fall: assert property ($fell(irq) |-> $past(avs_write && !avs_waitrequest, 2))
      else $error("interrupt fell without a register write.");
   a_irq_rise: assert property ($rose(irq) |-> $past(avs_write && !avs_waitrequest, 2)
      || $past(evt.tx_frame_done || evt.rx_frame_ready || evt.tx_desc_host_owned
      || evt.rx_desc_fetch || evt.tx_stopped || evt.rx_stopped, 2)
      || ($past(evt.link_up, 2) != $past(evt.link_up, 3)))
      else $error("interrupt rose without a cause.");
endmodule
bind mdiu_top mdiu_top_sva u_sva (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .evt(evt), .ctl(ctl), .irq(irq));

// ### tb_mac_dma_interrupt_unit.sv
// Self-checking bench for the MAC DMA interrupt unit.
// Assumes the designer's two-cycle bus access and edge-sampled events.
`timescale 1ns/1ps
module tb_mac_dma_interrupt_unit;
   import mdiu_pkg::*;
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   logic [ADDR_W-1:0] avs_address = '0;
   logic              avs_read = 1'b0;
   logic              avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = '0;
   logic [BE_W-1:0]   avs_byteenable = 4'hF;
   logic [DATA_W-1:0] avs_readdata;
   logic              avs_waitrequest;
   mdiu_evt_t         evt = '0;
   mdiu_ctl_t         ctl;
   logic              irq;
   int                bad_count = 0;
   int                cmp_count = 0;
   always #5 clk = ~clk;
   mdiu_top dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .evt(evt), .ctl(ctl),
      .irq(irq));
   ////////////////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Entered just after an edge; ends one edge after release so calls never collide.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      avs_byteenable <= be;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      chk("bus answer", 32'h1, {31'h0, n < 20});
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'hF, q);
   endtask
   task automatic rd(input string name, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hF, q);
      chk(name, e, q);
   endtask
   // Status bit positions fire their source; code 0, or any other code, is a receive frame arrival.
   task automatic fire(input int b, input logic dev_owned);
      case (b)
         BIT_LINK_CHANGE: evt.link_up <= ~evt.link_up;
         BIT_TX_DONE:     evt.tx_frame_done <= 1'b1;
         BIT_RX_DONE:     evt.rx_frame_ready <= 1'b1;
         BIT_TX_UNAVAIL:  evt.tx_desc_host_owned <= 1'b1;
         BIT_RX_UNAVAIL:  evt <= '{link_up: evt.link_up, rx_desc_fetch: 1'b1,
                                  rx_desc_host_owned: !dev_owned, default: 1'b0};
         BIT_TX_STOPPED:  evt.tx_stopped <= 1'b1;
         BIT_RX_STOPPED:  evt.rx_stopped <= 1'b1;
         default:         evt.rx_frame_arrival <= 1'b1;
      endcase
      @(posedge clk);
      evt <= '{link_up: evt.link_up, default: 1'b0};
      @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd("enable", OFS_IRQ_EN, 32'h0);
      rd("status", OFS_IRQ_ST, 32'h0);
      rd("unmapped", 8'h40, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
   endtask
   task automatic t_enable();
      logic [31:0] q;
      wr(OFS_IRQ_EN, 32'hFFFFFFFF);
      rd("enable", OFS_IRQ_EN, 32'hFE000000);
      bus(1'b1, OFS_IRQ_EN, 32'h0, 4'h7, q);
      rd("enable lane", OFS_IRQ_EN, 32'hFE000000);
      wr(OFS_IRQ_EN, 32'h0);
   endtask
   task automatic t_sources();
      logic [31:0] m;
      for (int b = SRC_MSB; b >= SRC_LSB; b--) begin
         m = 32'h1 << b;
         fire(b, 1'b0);
         rd("status set", OFS_IRQ_ST, m);
         rd("status kept", OFS_IRQ_ST, m);
         wr(OFS_IRQ_ST, ~m);
         rd("status zero write", OFS_IRQ_ST, m);
         wr(OFS_IRQ_ST, m);
         rd("status cleared", OFS_IRQ_ST, 32'h0);
      end
   endtask
   task automatic t_suspend();
      rd("suspended", OFS_DMA_ST, 32'h3);
      wr(OFS_TX_START, 32'h5A);
      rd("tx restarted", OFS_DMA_ST, 32'h2);
      fire(BIT_RX_UNAVAIL, 1'b0);
      rd("rx repeat", OFS_IRQ_ST, 32'h0);
      fire(BIT_RX_UNAVAIL, 1'b1);
      fire(BIT_RX_UNAVAIL, 1'b0);
      rd("rx after owned", OFS_IRQ_ST, 32'h08000000);
      wr(OFS_RX_START, 32'h0);
      rd("rx started", OFS_DMA_ST, 32'h0);
      fire(BIT_RX_UNAVAIL, 1'b0);
      evt.rx_frame_arrival <= 1'b1;
      @(posedge clk);
      evt.rx_frame_arrival <= 1'b0;
      @(posedge clk);
      chk("rx resume pulse", 32'h1, {31'h0, ctl.rx_resume});
      rd("rx resumed", OFS_DMA_ST, 32'h0);
      wr(OFS_IRQ_ST, 32'hFE000000);
   endtask
   task automatic t_irq();
      logic [31:0] q;
      wr(OFS_IRQ_EN, 32'h40000000);
      fire(BIT_RX_DONE, 1'b0);
      rd("masked", OFS_IRQ_ST, 32'h20000000);
      chk("irq masked", 32'h0, {31'h0, irq});
      fire(BIT_TX_DONE, 1'b0);
      rd("both", OFS_IRQ_ST, 32'h60000000);
      chk("irq raised", 32'h1, {31'h0, irq});
      wr(OFS_IRQ_ST, 32'h40000000);
      rd("left", OFS_IRQ_ST, 32'h20000000);
      chk("irq dropped", 32'h0, {31'h0, irq});
      bus(1'b1, OFS_IRQ_ST, 32'h20000000, 4'h7, q);
      rd("status lane", OFS_IRQ_ST, 32'h20000000);
      wr(OFS_IRQ_ST, 32'h20000000);
   endtask
   // The event is held across both edges of the clearing write.
   task automatic t_race();
      evt.tx_frame_done <= 1'b1;
      avs_address <= OFS_IRQ_ST;
      avs_writedata <= 32'h40000000;
      avs_write <= 1'b1;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      evt.tx_frame_done <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
      rd("set beats clear", OFS_IRQ_ST, 32'h40000000);
      wr(OFS_IRQ_EN, 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_enable();
      t_sources();
      t_suspend();
      t_irq();
      t_race();
      wrap_up();
   end
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      wrap_up();
   end
endmodule
